/* core/ttr_core.sv */
// threshold trigger, timing signal routing fabric and general-purpose digital lines
`timescale 1ns/1ps

// Functional notes
// - trigger source: direct pin or amplifier
// - direct pin levels: +-10 V, 78 mV steps
// - amplifier levels: full scale over 256 codes
// - five modes; thresholds written independently
// - below-low: trigger while signal under low
// - above-high: trigger while signal over high
// - inside: trigger while between both thresholds
// - high-hysteresis: set above high, release below low
// - low-hysteresis: set below low, release above high
// - trigger selectable by every timing section
// - eight digital lines, per-line direction
// - digital lines undriven after reset
// - lines six, seven feed counter directions
// - thirteen timing signals, pin or internal source
// - conversion strobe: pins, interval count, counter zero
// - every pin reaches every timing multiplexer
// - per-pin output enable drives assigned signal
// - internal 20 MHz timebase as frequency source
module ttr_core
   import ttr_pkg::*;
#(
   parameter int N_PINS = ttr_pkg::NUM_PINS,
   parameter int N_TIMING = ttr_pkg::NUM_TIMING,
   parameter int N_DIO = ttr_pkg::NUM_DIO
)
(
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic [ttr_pkg::ADDR_W-1:0] i_addr,
   input wire logic [ttr_pkg::DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [ttr_pkg::DATA_W-1:0] o_rdata,
   input wire logic [ttr_pkg::CODE_W-1:0] i_direct_trigger_pin_code,
   input wire logic [ttr_pkg::CODE_W-1:0] i_gain_amplifier_code,
   output logic o_trigger,
   input wire logic [N_PINS-1:0] i_routable_function_pin,
   output logic [N_PINS-1:0] o_routable_function_pin,
   output logic [N_PINS-1:0] o_routable_function_pin_oe,
   input wire logic [N_TIMING-1:0] i_internal_timing,
   input wire logic i_sample_interval_terminal_count,
   input wire logic i_counter_zero_output,
   output logic [N_TIMING-1:0] o_timing,
   input wire logic [N_DIO-1:0] i_dio,
   output logic [N_DIO-1:0] o_dio,
   output logic [N_DIO-1:0] o_dio_oe,
   output logic [1:0] o_counter_up_down,
   output logic o_timebase_20mhz,
   output logic o_timebase_tick
);
   import ttr_pkg::*;

   // software state
   logic src_amp;
   logic [MODE_W-1:0] mode;
   logic [CODE_W-1:0] low_threshold;
   logic [CODE_W-1:0] high_threshold;
   logic [N_DIO-1:0] dio_dir;
   logic [N_DIO-1:0] dio_out;
   logic [N_PINS-1:0] pin_oe;
   logic [SEL_W-1:0] tsel [N_TIMING];
   logic [MAP_W-1:0] pmap [N_PINS];

   // synchronisers for everything that arrives from pins
   logic [N_PINS-1:0] pin_meta;
   logic [N_PINS-1:0] pin_sync;
   logic [N_DIO-1:0] dio_meta;
   logic [N_DIO-1:0] dio_sync;
   logic [CODE_W-1:0] direct_meta;
   logic [CODE_W-1:0] direct_sync;
   logic [CODE_W-1:0] amp_meta;
   logic [CODE_W-1:0] amp_sync;

   // timebase and trigger state
   logic [TB_CNT_W-1:0] tb_cnt;
   logic tb_tick;
   logic tb_level;
   logic [CODE_W-1:0] level;
   logic trig;
   logic next_trig;
   logic [DATA_W-1:0] next_rdata;

   // two flip-flops on every pin input before any logic reads it
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         pin_meta <= '0;
         pin_sync <= '0;
         dio_meta <= '0;
         dio_sync <= '0;
      end
      else
      begin
         pin_meta <= i_routable_function_pin;
         pin_sync <= pin_meta;
         dio_meta <= i_dio;
         dio_sync <= dio_meta;
      end
   end

   // level codes come from converters that hold them steady between samples,
   // so a plain two-stage pass is enough; a moving code may be seen one stage late
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         direct_meta <= '0;
         direct_sync <= '0;
         amp_meta <= '0;
         amp_sync <= '0;
      end
      else
      begin
         direct_meta <= i_direct_trigger_pin_code;
         direct_sync <= direct_meta;
         amp_meta <= i_gain_amplifier_code;
         amp_sync <= amp_meta;
      end
   end

   // divide the system clock down to the timebase
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         tb_cnt <= '0;
         tb_tick <= 1'b0;
         tb_level <= 1'b0;
      end
      else
      begin
         tb_tick <= (tb_cnt == TB_CNT_W'(TB_DIV - 1));
         if (tb_cnt == TB_CNT_W'(TB_DIV - 1))
         begin
            tb_cnt <= '0;
         end
         else
         begin
            tb_cnt <= tb_cnt + 1'b1;
         end
         tb_level <= (tb_cnt < TB_CNT_W'(TB_HALF));
      end
   end

   // control, threshold and line registers
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         src_amp <= 1'b0;
         mode <= MODE_W'(TTR_BELOW_LOW);
         low_threshold <= RST_LOW;
         high_threshold <= RST_HIGH;
         dio_dir <= '0;
         dio_out <= '0;
         pin_oe <= '0;
      end
      else if (i_wr)
      begin
         if (i_addr == ADDR_CTRL)
         begin
            src_amp <= i_wdata[CTRL_SRC_BIT];
            mode <= i_wdata[CTRL_MODE_LSB +: MODE_W];
         end
         if (i_addr == ADDR_LOW)
         begin
            low_threshold <= i_wdata[CODE_W-1:0];
         end
         if (i_addr == ADDR_HIGH)
         begin
            high_threshold <= i_wdata[CODE_W-1:0];
         end
         if (i_addr == ADDR_DIO_DIR)
         begin
            dio_dir <= i_wdata[N_DIO-1:0];
         end
         if (i_addr == ADDR_DIO_OUT)
         begin
            dio_out <= i_wdata[N_DIO-1:0];
         end
         if (i_addr == ADDR_PIN_OE)
         begin
            pin_oe <= i_wdata[N_PINS-1:0];
         end
      end
   end

   // source selects, one word per timing signal
   for (genvar g = 0; g < N_TIMING; g++)
   begin : g_tsel
      localparam logic [ADDR_W-1:0] TSEL_ADDR = ADDR_W'(ADDR_TSEL_BASE + 4 * g);
      always_ff @(posedge i_sys_clk)
      begin
         if (i_rst)
         begin
            tsel[g] <= SRC_INTERNAL;
         end
         else if (i_wr && i_addr == TSEL_ADDR)
         begin
            tsel[g] <= i_wdata[SEL_W-1:0];
         end
      end

      // any pin may feed any signal, and several signals may share a pin
      always_ff @(posedge i_sys_clk)
      begin
         if (i_rst)
         begin
            o_timing[g] <= 1'b0;
         end
         else if (tsel[g] <= SRC_LAST_PIN)
         begin
            o_timing[g] <= pin_sync[tsel[g]];
         end
         else
         begin
            case (tsel[g])
               SRC_INTERNAL: o_timing[g] <= i_internal_timing[g];
               SRC_TRIGGER: o_timing[g] <= trig;
               SRC_SAMPLE_TC: o_timing[g] <= i_sample_interval_terminal_count;
               SRC_COUNTER0: o_timing[g] <= i_counter_zero_output;
               default: o_timing[g] <= 1'b0;
            endcase
         end
      end
   end

   // per-pin output assignment and driver
   for (genvar p = 0; p < N_PINS; p++)
   begin : g_pin
      localparam logic [ADDR_W-1:0] PMAP_ADDR = ADDR_W'(ADDR_PMAP_BASE + 4 * p);
      always_ff @(posedge i_sys_clk)
      begin
         if (i_rst)
         begin
            pmap[p] <= '0;
         end
         else if (i_wr && i_addr == PMAP_ADDR)
         begin
            pmap[p] <= i_wdata[MAP_W-1:0];
         end
      end

      // an out-of-range map drives low rather than an arbitrary signal
      always_ff @(posedge i_sys_clk)
      begin
         if (i_rst)
         begin
            o_routable_function_pin[p] <= 1'b0;
            o_routable_function_pin_oe[p] <= 1'b0;
         end
         else
         begin
            o_routable_function_pin_oe[p] <= pin_oe[p];
            if (32'(pmap[p]) < N_TIMING)
            begin
               o_routable_function_pin[p] <= o_timing[pmap[p]];
            end
            else
            begin
               o_routable_function_pin[p] <= 1'b0;
            end
         end
      end
   end

   // pick the level being compared; both sources are 8-bit codes, the direct
   // code being the pin voltage quantized in fixed steps across the full span
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         level <= '0;
      end
      else if (tb_tick)
      begin
         level <= src_amp ? amp_sync : direct_sync;
      end
   end

   // comparison per mode; hysteresis modes hold their state between the levels
   always_comb
   begin
      next_trig = 1'b0;
      case (mode)
         MODE_W'(TTR_BELOW_LOW): next_trig = (level < low_threshold);
         MODE_W'(TTR_ABOVE_HIGH): next_trig = (level > high_threshold);
         MODE_W'(TTR_INSIDE): next_trig = (level > low_threshold) && (level < high_threshold);
         MODE_W'(TTR_HYST_HIGH):
         begin
            if (level > high_threshold)
            begin
               next_trig = 1'b1;
            end
            else if (level < low_threshold)
            begin
               next_trig = 1'b0;
            end
            else
            begin
               next_trig = trig;
            end
         end
         MODE_W'(TTR_HYST_LOW):
         begin
            if (level < low_threshold)
            begin
               next_trig = 1'b1;
            end
            else if (level > high_threshold)
            begin
               next_trig = 1'b0;
            end
            else
            begin
               next_trig = trig;
            end
         end
         default: next_trig = 1'b0;
      endcase
   end

   // evaluated once per timebase period, on the same edge that takes a new level, so it uses the level taken one period earlier
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         trig <= 1'b0;
      end
      else if (tb_cnt == '0)
      begin
         trig <= next_trig;
      end
   end

   // digital lines and counter direction sensing
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         o_dio <= '0;
         o_dio_oe <= '0;
         o_counter_up_down <= '0;
         o_trigger <= 1'b0;
         o_timebase_20mhz <= 1'b0;
         o_timebase_tick <= 1'b0;
      end
      else
      begin
         o_dio <= dio_out;
         o_dio_oe <= dio_dir;
         // sensed from the pin level only; direction and data are untouched
         o_counter_up_down <= dio_sync[UPDN_LINE_LSB +: 2];
         o_trigger <= trig;
         o_timebase_20mhz <= tb_level;
         o_timebase_tick <= tb_tick;
      end
   end

   // read multiplexer; unmapped addresses read zero
   always_comb
   begin
      next_rdata = '0;
      if (i_addr == ADDR_CTRL)
      begin
         next_rdata[CTRL_SRC_BIT] = src_amp;
         next_rdata[CTRL_MODE_LSB +: MODE_W] = mode;
      end
      if (i_addr == ADDR_LOW)
      begin
         next_rdata[CODE_W-1:0] = low_threshold;
      end
      if (i_addr == ADDR_HIGH)
      begin
         next_rdata[CODE_W-1:0] = high_threshold;
      end
      if (i_addr == ADDR_DIO_DIR)
      begin
         next_rdata[N_DIO-1:0] = dio_dir;
      end
      if (i_addr == ADDR_DIO_OUT)
      begin
         next_rdata[N_DIO-1:0] = dio_out;
      end
      if (i_addr == ADDR_STATUS)
      begin
         next_rdata[STAT_DIO_LSB +: N_DIO] = dio_sync;
         next_rdata[STAT_TRIG_BIT] = trig;
         next_rdata[STAT_UPDN_LSB +: 2] = dio_sync[UPDN_LINE_LSB +: 2];
      end
      if (i_addr == ADDR_PIN_OE)
      begin
         next_rdata[N_PINS-1:0] = pin_oe;
      end
      for (int k = 0; k < N_TIMING; k++)
      begin
         if (i_addr == ADDR_W'(ADDR_TSEL_BASE + 4 * k))
         begin
            next_rdata[SEL_W-1:0] = tsel[k];
         end
      end
      for (int k = 0; k < N_PINS; k++)
      begin
         if (i_addr == ADDR_W'(ADDR_PMAP_BASE + 4 * k))
         begin
            next_rdata[MAP_W-1:0] = pmap[k];
         end
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         o_rdata <= '0;
      end
      else if (i_rd)
      begin
         o_rdata <= next_rdata;
      end
      else
      begin
         o_rdata <= '0;
      end
   end

endmodule

/* core/ttr_pkg.sv */
// constants, register map and mode encodings for the trigger and timing routing block
package ttr_pkg;

   // bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // fabric sizes
   localparam int NUM_PINS = 10;
   localparam int NUM_TIMING = 13;
   localparam int NUM_DIO = 8;
   localparam int CODE_W = 8;
   localparam int LEVEL_STEPS = 256;
   localparam int DIRECT_STEP_MV = 78;
   localparam int DIRECT_SPAN_MV = 10000;
   localparam int SEL_W = 4;
   localparam int MAP_W = 4;

   // source select codes for a timing signal multiplexer
   localparam logic [SEL_W-1:0] SRC_LAST_PIN = 4'h9;
   localparam logic [SEL_W-1:0] SRC_INTERNAL = 4'ha;
   localparam logic [SEL_W-1:0] SRC_TRIGGER = 4'hb;
   localparam logic [SEL_W-1:0] SRC_SAMPLE_TC = 4'hc;
   localparam logic [SEL_W-1:0] SRC_COUNTER0 = 4'hd;

   // index of the conversion strobe among the timing signals
   localparam int CONVERT_IDX = 0;

   // timebase
   localparam int SYS_CLK_HZ = 200000000;
   localparam int TIMEBASE_HZ = 20000000;
   localparam int TB_DIV = SYS_CLK_HZ / TIMEBASE_HZ;
   localparam int TB_HALF = TB_DIV / 2;
   localparam int TB_CNT_W = 4;

   // register offsets (byte addresses, one word each)
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_LOW = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_HIGH = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_DIO_DIR = 8'h0c;
   localparam logic [ADDR_W-1:0] ADDR_DIO_OUT = 8'h10;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h14;
   localparam logic [ADDR_W-1:0] ADDR_PIN_OE = 8'h18;
   localparam logic [ADDR_W-1:0] ADDR_TSEL_BASE = 8'h20;
   localparam logic [ADDR_W-1:0] ADDR_PMAP_BASE = 8'h60;

   // control field layout
   localparam int CTRL_SRC_BIT = 0;
   localparam int CTRL_MODE_LSB = 1;
   localparam int MODE_W = 3;

   // status field layout
   localparam int STAT_DIO_LSB = 0;
   localparam int STAT_TRIG_BIT = 8;
   localparam int STAT_UPDN_LSB = 9;
   localparam int UPDN_LINE_LSB = 6;

   // reset values
   localparam logic [CODE_W-1:0] RST_LOW = 8'h00;
   localparam logic [CODE_W-1:0] RST_HIGH = 8'hff;

   // trigger modes
   typedef enum logic [MODE_W-1:0] {
      TTR_BELOW_LOW,
      TTR_ABOVE_HIGH,
      TTR_INSIDE,
      TTR_HYST_HIGH,
      TTR_HYST_LOW
   } ttr_mode_t;

endpackage

/* test/ttr_core_bench.sv */
// self-checking bench for the trigger and timing routing block
`timescale 1ns/1ps
module ttr_core_bench;
   import ttr_pkg::*;
   logic i_sys_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [7:0] i_addr = 8'h00;
   logic [31:0] i_wdata = 32'h0;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [7:0] dcode = 8'h00;
   logic [7:0] acode = 8'h00;
   logic [9:0] ext_pin = 10'h0;
   logic [7:0] ext_dio = 8'h00;
   logic [12:0] itim = 13'h0;
   logic stc = 1'b0;
   logic c0 = 1'b0;
   logic rd_seen = 1'b0;
   logic [31:0] exp_q [$];
   int errors = 0;
   int n_compared = 0;
   int seed = 22;
   int p;
   int n;
   logic [31:0] r;
   logic [31:0] o;
   logic [31:0] lvl;
   wire logic [31:0] o_rdata;
   wire logic o_trigger;
   wire logic [9:0] pin_lvl;
   wire logic [9:0] pin_drv;
   wire logic [9:0] pin_oe;
   wire logic [12:0] o_timing;
   wire logic [7:0] dio_lvl;
   wire logic [7:0] dio_drv;
   wire logic [7:0] dio_oe;
   wire logic [1:0] updn;
   wire logic tb_clk;
   wire logic tb_tick;

   // 200 mhz system clock
   always #2.5 i_sys_clk = ~i_sys_clk;

   ttr_core dut_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(o_rdata), .i_direct_trigger_pin_code(dcode), .i_gain_amplifier_code(acode),
      .o_trigger(o_trigger), .i_routable_function_pin(pin_lvl), .o_routable_function_pin(pin_drv),
      .o_routable_function_pin_oe(pin_oe), .i_internal_timing(itim), .i_sample_interval_terminal_count(stc),
      .i_counter_zero_output(c0), .o_timing(o_timing), .i_dio(dio_lvl), .o_dio(dio_drv), .o_dio_oe(dio_oe),
      .o_counter_up_down(updn), .o_timebase_20mhz(tb_clk), .o_timebase_tick(tb_tick));

   ttr_far_end far_u (.i_pin_drv(pin_drv), .i_pin_oe(pin_oe), .i_ext_pin(ext_pin), .i_dio_drv(dio_drv),
      .i_dio_oe(dio_oe), .i_ext_dio(ext_dio), .o_pin(pin_lvl), .o_dio(dio_lvl));

   task automatic stop_test();
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0)
      begin
         $display("Simulation passed");
      end
      else
      begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk_vec(input logic [31:0] got, input logic [31:0] want);
      n_compared++;
      if (got !== want)
      begin
         errors++;
         $display("BAD %0t output %h want %h", $time, got, want);
      end
   endtask

   task automatic chk_rd(input logic [31:0] got);
      logic [31:0] want;
      want = 32'h0;
      if (exp_q.size() == 0)
      begin
         errors++;
         $display("BAD %0t read data with no request", $time);
      end
      else
      begin
         want = exp_q.pop_front();
         n_compared++;
         if (got !== want)
         begin
            errors++;
            $display("BAD %0t read %h want %h", $time, got, want);
         end
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_sys_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_sys_clk);
      i_wr <= 1'b0;
   endtask

   // the expected word is noted before the strobe goes out
   task automatic rd(input logic [7:0] a, input logic [31:0] want);
      exp_q.push_back(want);
      @(posedge i_sys_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
   endtask

   // 30 cycles cover sync, one timebase wait, one evaluation and the output flop
   task automatic trig(input logic [7:0] d, input logic [7:0] a, input logic want);
      @(posedge i_sys_clk);
      dcode <= d;
      acode <= a;
      repeat (30) @(posedge i_sys_clk);
      chk_vec(32'(o_trigger), 32'(want));
   endtask

   // read data stands in the cycle after the strobe only
   always @(posedge i_sys_clk)
   begin
      rd_seen <= i_rd && !i_rst;
      if (rd_seen)
      begin
         chk_rd(o_rdata);
      end
   end

   // the whole run is under a thousand cycles; far beyond that is a hang
   initial
   begin
      repeat (20000) @(posedge i_sys_clk);
      errors++;
      $display("BAD %0t timeout", $time);
      stop_test();
   end

   initial
   begin
      repeat (2) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      itim <= 13'($random(seed));
      repeat (4) @(posedge i_sys_clk);
      chk_vec(32'(o_timing), 32'(itim));
      chk_vec(32'(dio_oe), 32'h0);
      chk_vec(32'(pin_oe), 32'h0);
      rd(ADDR_CTRL, 32'h0);
      rd(ADDR_HIGH, 32'(RST_HIGH));
      rd(ADDR_TSEL_BASE, 32'(SRC_INTERNAL));
      r = $random(seed);
      wr(ADDR_LOW, r);
      rd(ADDR_LOW, r & 32'hff);
      // random direction and drive; undriven lines take the outside level
      r = $random(seed);
      o = $random(seed);
      ext_dio <= 8'($random(seed));
      wr(ADDR_DIO_DIR, r);
      wr(ADDR_DIO_OUT, o);
      repeat (8) @(posedge i_sys_clk);
      lvl = 32'((r[7:0] & o[7:0]) | (~r[7:0] & ext_dio));
      chk_vec(32'(dio_oe), 32'(r[7:0]));
      chk_vec(32'(dio_drv), 32'(o[7:0]));
      chk_vec(32'(updn), 32'(lvl[7:6]));
      rd(ADDR_DIO_DIR, r & 32'hff);
      // trigger modes on the direct pin code, low 0x40 and high 0xc0
      wr(ADDR_LOW, 32'h40);
      wr(ADDR_HIGH, 32'hc0);
      wr(ADDR_CTRL, 32'h0);
      trig(8'h30, 8'h00, 1'b1);
      trig(8'h40, 8'h00, 1'b0);
      wr(ADDR_CTRL, 32'(TTR_ABOVE_HIGH) << CTRL_MODE_LSB);
      trig(8'hd0, 8'h00, 1'b1);
      trig(8'h50, 8'h00, 1'b0);
      wr(ADDR_CTRL, 32'(TTR_INSIDE) << CTRL_MODE_LSB);
      trig(8'h80, 8'h00, 1'b1);
      trig(8'h30, 8'h00, 1'b0);
      trig(8'hd0, 8'h00, 1'b0);
      wr(ADDR_CTRL, 32'(TTR_HYST_HIGH) << CTRL_MODE_LSB);
      trig(8'h20, 8'h00, 1'b0);
      trig(8'h80, 8'h00, 1'b0);
      trig(8'hd0, 8'h00, 1'b1);
      trig(8'h80, 8'h00, 1'b1);
      trig(8'h20, 8'h00, 1'b0);
      wr(ADDR_CTRL, 32'(TTR_HYST_LOW) << CTRL_MODE_LSB);
      trig(8'hd0, 8'h00, 1'b0);
      trig(8'h80, 8'h00, 1'b0);
      trig(8'h20, 8'h00, 1'b1);
      trig(8'h80, 8'h00, 1'b1);
      trig(8'hd0, 8'h00, 1'b0);
      // amplifier source, below-low; the direct code must be ignored
      wr(ADDR_CTRL, 32'h1);
      trig(8'h30, 8'h50, 1'b0);
      trig(8'h50, 8'h30, 1'b1);
      wr(ADDR_HIGH, 32'h00);
      trig(8'h50, 8'h30, 1'b1);
      rd(ADDR_STATUS, (32'(lvl[7:6]) << STAT_UPDN_LSB) | (32'h1 << STAT_TRIG_BIT) | lvl);
      wr(ADDR_TSEL_BASE + 8'h04, 32'(SRC_TRIGGER));
      repeat (4) @(posedge i_sys_clk);
      chk_vec(32'(o_timing[1]), 32'h1);
      // routing: pin 0 drives timing 2 out, the test pin is one of 1..9
      p = ($unsigned($random(seed)) % 9) + 1;
      ext_pin <= 10'($random(seed));
      stc <= 1'b1;
      c0 <= 1'b1;
      wr(ADDR_TSEL_BASE, 32'(p));
      wr(ADDR_TSEL_BASE + 8'h14, 32'(p));
      wr(ADDR_TSEL_BASE + 8'h08, 32'(SRC_SAMPLE_TC));
      wr(ADDR_TSEL_BASE + 8'h0c, 32'(SRC_COUNTER0));
      wr(ADDR_PMAP_BASE, 32'h2);
      wr(ADDR_PIN_OE, 32'h1);
      repeat (6) @(posedge i_sys_clk);
      chk_vec(32'(o_timing[0]), 32'(ext_pin[p]));
      chk_vec(32'(o_timing[5]), 32'(ext_pin[p]));
      chk_vec(32'(o_timing[2]), 32'h1);
      chk_vec(32'(o_timing[3]), 32'h1);
      chk_vec(32'(pin_oe), 32'h1);
      chk_vec(32'(pin_drv[0]), 32'h1);
      stc <= 1'b0;
      repeat (6) @(posedge i_sys_clk);
      chk_vec(32'(pin_drv[0]), 32'h0);
      // ten system cycles per timebase period
      n = 0;
      repeat (100)
      begin
         @(posedge i_sys_clk);
         if (tb_tick)
         begin
            n++;
         end
      end
      chk_vec(32'(n), 32'd10);
      // reset in mid-run releases every line and pin again
      @(posedge i_sys_clk);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      repeat (2) @(posedge i_sys_clk);
      chk_vec(32'(dio_oe), 32'h0);
      chk_vec(32'(pin_oe), 32'h0);
      rd(ADDR_LOW, 32'(RST_LOW));
      repeat (3) @(posedge i_sys_clk);
      if (exp_q.size() != 0)
      begin
         errors++;
         $display("BAD %0t read answers missing", $time);
      end
      stop_test();
   end
endmodule

/* test/ttr_core_sva.sv */
// assertion checker on the trigger and timing routing ports
`timescale 1ns/1ps
module ttr_sva
   import ttr_pkg::*;
#(
   parameter int N_PINS = 10,
   parameter int N_DIO = 8
)
(
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [31:0] o_rdata,
   input wire logic o_trigger,
   input wire logic [N_PINS-1:0] o_routable_function_pin_oe,
   input wire logic [N_DIO-1:0] i_dio,
   input wire logic [N_DIO-1:0] o_dio,
   input wire logic [N_DIO-1:0] o_dio_oe,
   input wire logic [1:0] o_counter_up_down,
   input wire logic o_timebase_20mhz,
   input wire logic o_timebase_tick
);
   logic [2:0] run;
   // edges since reset, saturating, so $past never looks into reset
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
         run <= 3'h0;
      else if (run != 3'h7)
         run <= run + 3'h1;
   end
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   a_lines_released: assert property ($fell(i_rst) |-> o_dio_oe == '0)
      else $error("line driven after reset");
   a_pins_released: assert property ($fell(i_rst) |-> o_routable_function_pin_oe == '0)
      else $error("pin driven after reset");
   a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == '0)
      else $error("read data outside its cycle");
   a_low_readback: assert property (i_wr && i_addr == ADDR_LOW ##2 i_rd && i_addr == ADDR_LOW
      |=> o_rdata == ($past(i_wdata, 3) & 32'hff))
      else $error("low threshold readback wrong");
   // register then output flip-flop: the pin sees a write two edges later
   a_pin_oe_write: assert property (i_wr && i_addr == ADDR_PIN_OE
      |-> ##2 o_routable_function_pin_oe == $past(i_wdata[N_PINS-1:0], 2))
      else $error("pin enable not taken");
   a_dir_write: assert property (i_wr && i_addr == ADDR_DIO_DIR |-> ##2 o_dio_oe == $past(i_wdata[7:0], 2))
      else $error("line direction not taken");
   a_out_write: assert property (i_wr && i_addr == ADDR_DIO_OUT |-> ##2 o_dio == $past(i_wdata[7:0], 2))
      else $error("line value not taken");
   a_updn_sense: assert property (run == 3'h7 |-> o_counter_up_down == $past(i_dio[7:6], 3))
      else $error("count direction not from lines six and seven");
   a_tick_period: assert property (o_timebase_tick |=> !o_timebase_tick [*8] ##1 !o_timebase_tick
      ##1 o_timebase_tick)
      else $error("timebase tick not every ten cycles");
   a_tb_square: assert property ($rose(o_timebase_20mhz) |=> o_timebase_20mhz [*4] ##1 !o_timebase_20mhz)
      else $error("timebase high phase not five cycles");
   a_trig_gated: assert property ($changed(o_trigger) |=> $stable(o_trigger) [*8])
      else $error("trigger moved between timebase evaluations");
endmodule
bind ttr_core ttr_sva #(.N_PINS(N_PINS), .N_DIO(N_DIO)) sva_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
   .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_trigger(o_trigger),
   .o_routable_function_pin_oe(o_routable_function_pin_oe), .i_dio(i_dio), .o_dio(o_dio),
   .o_dio_oe(o_dio_oe), .o_counter_up_down(o_counter_up_down), .o_timebase_20mhz(o_timebase_20mhz),
   .o_timebase_tick(o_timebase_tick));

/* test/ttr_far_end.sv */
// far-side model: outside circuitry on the function pins and lines
`timescale 1ns/1ps
module ttr_far_end
(
   input wire logic [9:0] i_pin_drv,
   input wire logic [9:0] i_pin_oe,
   input wire logic [9:0] i_ext_pin,
   input wire logic [7:0] i_dio_drv,
   input wire logic [7:0] i_dio_oe,
   input wire logic [7:0] i_ext_dio,
   output wire logic [9:0] o_pin,
   output wire logic [7:0] o_dio
);
   // a driven pin shows the block's value, an undriven one the outside source
   assign o_pin = (i_pin_oe & i_pin_drv) | (~i_pin_oe & i_ext_pin);
   assign o_dio = (i_dio_oe & i_dio_drv) | (~i_dio_oe & i_ext_dio);
endmodule
